/* File: src/clk_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl
  import clk_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic internal_rc_clock_i,
  input wire logic external_fast_clock_i,
  input wire logic pll_clock_i,
  output logic external_fast_clock_en_o,
  output logic pll_en_o,
  output logic sys_clk_o,
  output logic ahb_clk_o,
  output logic fast_peripheral_bus_clk_o,
  output logic slow_peripheral_bus_clk_o,
  output logic irq_o
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DIV_W-1:0] div;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    src_e active;
    src_e target;
    sw_e sw;
    logic out_clk;
    logic sys_rise;
    logic [MON_CW-1:0] ext_cnt;
    logic [MON_CW-1:0] pll_cnt;
    logic ext_prev;
    logic pll_prev;
    logic ext_fail;
    logic pll_fail;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } st_s;

  st_s st_reg;
  st_s st_next;

  // One counter bit per ratio step, so the largest ratio still has a bit to tap
  localparam int PRESC_CNT_W = (1 << RATIO_W) - 1;

  presc_if ahb_p ();
  presc_if fast_p ();
  presc_if slow_p ();

  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Counts cycles without a level change; saturates at the limit
  function automatic logic [MON_CW-1:0] mon_step(input logic run, input logic lvl, input logic prev,
                                                 input logic [MON_CW-1:0] cnt);
    if (!run || (lvl != prev)) begin
      return '0;
    end else if (cnt == MON_LIMIT) begin
      return cnt;
    end else begin
      return cnt + 1'b1;
    end
  endfunction

  function automatic logic src_level(input src_e src);
    case (src)
      SRC_EXT: return external_fast_clock_i;
      SRC_PLL: return pll_clock_i;
      default: return internal_rc_clock_i;
    endcase
  endfunction

  function automatic logic src_ok(input src_e src, input logic [CTRL_W-1:0] ctrl, input logic ext_bad,
                                  input logic pll_bad);
    case (src)
      SRC_EXT: return ctrl[CTRL_EXT_EN] & ~ext_bad;
      SRC_PLL: return ctrl[CTRL_PLL_EN] & ~pll_bad & (~ctrl[CTRL_PLL_FROM_EXT] | ~ext_bad);
      SRC_RC: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Select codes 0 and 3 both mean the RC oscillator, so a stray code lands safe
  function automatic src_e sel_decode(input logic [CTRL_W-1:0] ctrl);
    case (ctrl[CTRL_SEL_LSB +: 2])
      2'(SRC_EXT): return SRC_EXT;
      2'(SRC_PLL): return SRC_PLL;
      default: return SRC_RC;
    endcase
  endfunction

  // Busy tells software that a switch still waits for a low phase
  function automatic logic [31:0] stat_word(input st_s s);
    logic [31:0] w;
    w = '0;
    w[STAT_ACT_LSB +: 2] = s.active;
    w[STAT_EXT_FAIL] = s.ext_fail;
    w[STAT_PLL_FAIL] = s.pll_fail;
    w[STAT_BUSY] = (s.sw != SW_RUN);
    return w;
  endfunction

  always_comb begin
    logic req;
    logic wr;
    logic ext_run;
    logic pll_run;
    logic pll_in;
    logic fallback;
    logic [31:0] wval;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    src_e want;
    st_next = st_reg;
    // A request is taken only while ack is low, so each access is acked once
    req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & st_reg.ack;
    wval = '0;
    ev = '0;
    clr = '0;
    want = SRC_RC;
    fallback = 1'b0;

    // Register writes land on the edge where the master sees ack
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          wval = wr_merge(32'(st_reg.ctrl), wb_dat_i, wb_sel_i);
          st_next.ctrl = wval[CTRL_W-1:0];
        end
        OFS_DIV: begin
          wval = wr_merge(32'(st_reg.div), wb_dat_i, wb_sel_i);
          st_next.div = wval[DIV_W-1:0];
        end
        OFS_IRQ_STAT: begin
          if (wb_sel_i[0]) begin
            clr = wb_dat_i[IRQ_W-1:0];
          end
        end
        OFS_IRQ_MASK: begin
          wval = wr_merge(32'(st_reg.irq_mask), wb_dat_i, wb_sel_i);
          st_next.irq_mask = wval[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Oscillator monitors
    ext_run = st_reg.ctrl[CTRL_EXT_EN];
    st_next.ext_prev = external_fast_clock_i;
    st_next.ext_cnt = mon_step(ext_run, external_fast_clock_i, st_reg.ext_prev, st_reg.ext_cnt);
    st_next.ext_fail = ext_run & (st_reg.ext_fail | (st_next.ext_cnt == MON_LIMIT));
    ev[IRQ_EXT_FAIL] = st_next.ext_fail & ~st_reg.ext_fail;

    // The PLL path is judged by its input, whose stall starves the PLL first
    pll_run = st_reg.ctrl[CTRL_PLL_EN];
    pll_in = st_reg.ctrl[CTRL_PLL_FROM_EXT] ? external_fast_clock_i : internal_rc_clock_i;
    st_next.pll_prev = pll_in;
    st_next.pll_cnt = mon_step(pll_run, pll_in, st_reg.pll_prev, st_reg.pll_cnt);
    st_next.pll_fail = pll_run & (st_reg.pll_fail | (st_next.pll_cnt == MON_LIMIT));
    ev[IRQ_PLL_FAIL] = st_next.pll_fail & ~st_reg.pll_fail;

    // A dead active source is abandoned at once; its low phase cannot be awaited
    if (!src_ok(st_reg.active, st_reg.ctrl, st_reg.ext_fail, st_reg.pll_fail)) begin
      fallback = 1'b1;
    end
    want = sel_decode(st_reg.ctrl);

    case (st_reg.sw)
      SW_RUN: begin
        st_next.out_clk = src_level(st_reg.active);
        if (fallback) begin
          st_next.target = SRC_RC;
          st_next.out_clk = 1'b0;
          st_next.sw = SW_NEW_LOW;
        end else if ((want != st_reg.active) && src_ok(want, st_reg.ctrl, st_reg.ext_fail, st_reg.pll_fail)) begin
          st_next.target = want;
          st_next.sw = SW_OLD_LOW;
        end
      end
      SW_OLD_LOW: begin
        // Except on fallback, the old clock is cut only in its low phase, so no runt pulse reaches the buses
        st_next.out_clk = src_level(st_reg.active);
        if (fallback || !src_level(st_reg.active)) begin
          st_next.out_clk = 1'b0;
          st_next.sw = SW_NEW_LOW;
          if (fallback) begin
            st_next.target = SRC_RC;
          end
        end
      end
      SW_NEW_LOW: begin
        st_next.out_clk = 1'b0;
        // A target that dies while awaited is given up for the RC oscillator
        if (!src_ok(st_reg.target, st_reg.ctrl, st_reg.ext_fail, st_reg.pll_fail)) begin
          st_next.target = SRC_RC;
        end else if (!src_level(st_reg.target)) begin
          st_next.active = st_reg.target;
          st_next.sw = SW_RUN;
          ev[IRQ_SWITCH] = 1'b1;
        end
      end
      default: begin
        st_next.sw = SW_RUN;
        st_next.active = SRC_RC;
        st_next.out_clk = 1'b0;
      end
    endcase

    // Fallback overrides a same-cycle software select so it cannot bounce back
    if (fallback) begin
      st_next.ctrl[CTRL_SEL_LSB +: 2] = 2'(SRC_RC);
    end
    // Prescalers count registered rises, so a switch cannot hand them a runt edge
    st_next.sys_rise = st_next.out_clk & ~st_reg.out_clk;

    // A new event wins over a write-one-to-clear in the same cycle
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // Read data is zero outside the acknowledge cycle
    st_next.ack = req;
    st_next.rdata = '0;
    if (req) begin
      case (wb_adr_i)
        OFS_CTRL: st_next.rdata = 32'(st_reg.ctrl);
        OFS_STAT: st_next.rdata = stat_word(st_reg);
        OFS_DIV: st_next.rdata = 32'(st_reg.div);
        OFS_IRQ_STAT: st_next.rdata = 32'(st_reg.irq_stat);
        OFS_IRQ_MASK: st_next.rdata = 32'(st_reg.irq_mask);
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Everything not named here clears, which means RC active and no flags
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.div <= DIV_RST;
      st_reg.irq_mask <= IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // AHB divides the system clock; both peripheral buses divide the AHB clock
  assign ahb_p.ratio = st_reg.div[DIV_AHB_LSB +: RATIO_W];
  assign ahb_p.src_level = st_reg.out_clk;
  assign ahb_p.src_rise = st_reg.sys_rise;
  assign fast_p.ratio = st_reg.div[DIV_FAST_LSB +: RATIO_W];
  assign fast_p.src_level = ahb_p.clk;
  assign fast_p.src_rise = ahb_p.rise;
  assign slow_p.ratio = st_reg.div[DIV_SLOW_LSB +: RATIO_W];
  assign slow_p.src_level = ahb_p.clk;
  assign slow_p.src_rise = ahb_p.rise;

  clk_prescaler #(.CNT_W(PRESC_CNT_W)) u_ahb_presc (.clk_i(clk_i), .rst_i(rst_i), .p(ahb_p.div));
  clk_prescaler #(.CNT_W(PRESC_CNT_W)) u_fast_presc (.clk_i(clk_i), .rst_i(rst_i), .p(fast_p.div));
  clk_prescaler #(.CNT_W(PRESC_CNT_W)) u_slow_presc (.clk_i(clk_i), .rst_i(rst_i), .p(slow_p.div));

  assign wb_dat_o = st_reg.rdata;
  assign wb_ack_o = st_reg.ack;
  assign external_fast_clock_en_o = st_reg.ctrl[CTRL_EXT_EN];
  assign pll_en_o = st_reg.ctrl[CTRL_PLL_EN];
  assign sys_clk_o = st_reg.out_clk;
  assign ahb_clk_o = ahb_p.clk;
  assign fast_peripheral_bus_clk_o = fast_p.clk;
  assign slow_peripheral_bus_clk_o = slow_p.clk;
  assign irq_o = st_reg.irq;

endmodule // clk_ctrl
`default_nettype wire

/* File: src/clk_ctrl_pkg.sv */
package clk_ctrl_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Control register layout
  localparam int CTRL_W = 5;
  localparam int CTRL_EXT_EN = 0;
  localparam int CTRL_PLL_EN = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_PLL_FROM_EXT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // Status register layout
  localparam int STAT_ACT_LSB = 0;
  localparam int STAT_EXT_FAIL = 2;
  localparam int STAT_PLL_FAIL = 3;
  localparam int STAT_BUSY = 4;

  // Prescaler register: three log2 ratio fields
  localparam int RATIO_W = 3;
  localparam int DIV_W = 12;
  localparam int DIV_AHB_LSB = 0;
  localparam int DIV_FAST_LSB = 4;
  localparam int DIV_SLOW_LSB = 8;
  localparam logic [DIV_W-1:0] DIV_RST = 12'h000;

  // Interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_EXT_FAIL = 0;
  localparam int IRQ_PLL_FAIL = 1;
  localparam int IRQ_SWITCH = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Oscillator monitor: a source with no level change for this long is dead
  localparam int CLK_PERIOD_NS = 50;
  localparam int MON_TIMEOUT_NS = 1000;
  localparam int MON_CW = 8;
  localparam logic [MON_CW-1:0] MON_LIMIT = MON_CW'(MON_TIMEOUT_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {SRC_RC, SRC_EXT, SRC_PLL} src_e;
  typedef enum logic [1:0] {SW_RUN, SW_OLD_LOW, SW_NEW_LOW} sw_e;

endpackage

/* File: src/presc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface presc_if;
  import clk_ctrl_pkg::*;
  logic [RATIO_W-1:0] ratio;
  logic src_level;
  logic src_rise;
  logic clk;
  logic rise;
  modport core (output ratio, output src_level, output src_rise, input clk, input rise);
  modport div (input ratio, input src_level, input src_rise, output clk, output rise);
endinterface // presc_if
`default_nettype wire

/* File: src/clk_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module clk_prescaler
  import clk_ctrl_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  presc_if.div p
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic clk;
    logic rise;
  } pst_s;

  pst_s st_reg;
  pst_s st_next;

  // Divides by 2**ratio; ratio 0 passes the source level straight on
  always_comb begin
    logic lvl;
    lvl = 1'b0;
    st_next = st_reg;
    if (p.src_rise) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    if (p.ratio == '0) begin
      lvl = p.src_level;
    end else begin
      lvl = st_next.cnt[p.ratio - 1'b1];
    end
    st_next.clk = lvl;
    st_next.rise = lvl & ~st_reg.clk;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign p.clk = st_reg.clk;
  assign p.rise = st_reg.rise;

endmodule // clk_prescaler
`default_nettype wire

/* File: tb/osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  input wire logic clk_i,
  input wire logic run_i,
  output logic osc_o
);
  parameter int HALF = 2;
  int cnt = 0;
  initial osc_o = 1'b0;
  // A dead oscillator parks low, as a stopped crystal would
  always @(posedge clk_i) begin
    cnt <= (cnt + 1) % HALF;
    if (!run_i) osc_o <= 1'b0;
    else if (cnt == HALF - 1) osc_o <= !osc_o;
  end
endmodule // osc_model
`default_nettype wire

/* File: tb/clk_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_assertions
  import clk_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic internal_rc_clock_i,
  input wire logic external_fast_clock_i,
  input wire logic pll_clock_i,
  input wire logic external_fast_clock_en_o,
  input wire logic pll_en_o,
  input wire logic sys_clk_o,
  input wire logic ahb_clk_o,
  input wire logic irq_o
);
  logic wrote;
  logic [7:0] stuck;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) wrote <= 1'b0;
    else if (wb_cyc_i && wb_stb_i && wb_we_i) wrote <= 1'b1;
  end
  // Cycles the enabled external clock has shown no level change
  always_ff @(posedge clk_i) begin
    if (rst_i || !external_fast_clock_en_o || external_fast_clock_i != $past(external_fast_clock_i)) stuck <= 8'h00;
    else if (stuck != 8'hff) stuck <= stuck + 8'h01;
  end
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_reset_outs: assert property (disable iff (1'b0) rst_i |=> !sys_clk_o && !ahb_clk_o && !irq_o && !wb_ack_o)
    else $error("outputs not cleared by reset");
  chk_enables_off: assert property (disable iff (1'b0) rst_i |=> !external_fast_clock_en_o && !pll_en_o)
    else $error("enables set after reset");
  chk_rc_default: assert property (!wrote && !$past(rst_i) |-> sys_clk_o == $past(internal_rc_clock_i))
    else $error("system clock not rc after reset");
  chk_rise_source: assert property ($rose(sys_clk_o) |->
    $past(internal_rc_clock_i) || $past(external_fast_clock_i) || $past(pll_clock_i))
    else $error("system clock rose with all sources low");
  chk_fallback_rc: assert property (stuck == 8'h1e |-> ##[1:60] (sys_clk_o == $past(internal_rc_clock_i)) [*8])
    else $error("no fallback to rc");
  cover property (stuck == 8'h1e);
  cover property ($rose(irq_o));
  cover property (wb_ack_o && wb_we_i);
endmodule // clk_ctrl_assertions
bind clk_ctrl clk_ctrl_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .internal_rc_clock_i, .external_fast_clock_i, .pll_clock_i, .external_fast_clock_en_o, .pll_en_o,
  .sys_clk_o, .ahb_clk_o, .irq_o);
`default_nettype wire

/* File: tb/clk_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_test;
  import clk_ctrl_pkg::*;
  logic clk_i, rst_i, req, we, run_ext;
  logic [7:0] adr;
  logic [31:0] wdat, q;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, rc, ext, pll, ext_en, irq;
  wire logic [3:0] clks;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int rises [4];
  osc_model #(.HALF(4)) u_rc (.clk_i, .run_i(1'b1), .osc_o(rc));
  osc_model #(.HALF(2)) u_ext (.clk_i, .run_i(run_ext), .osc_o(ext));
  osc_model #(.HALF(3)) u_pll (.clk_i, .run_i(1'b1), .osc_o(pll));
  clk_ctrl dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_dat_o, .wb_ack_o, .internal_rc_clock_i(rc), .external_fast_clock_i(ext),
    .pll_clock_i(pll), .external_fast_clock_en_o(ext_en), .pll_en_o(), .sys_clk_o(clks[0]),
    .ahb_clk_o(clks[1]), .fast_peripheral_bus_clk_o(clks[2]), .slow_peripheral_bus_clk_o(clks[3]), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = !clk_i;
  end
  task automatic report_and_stop;
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    req <= 1'b0;
    if (n == 20) chk(32'h0, 32'h1, "ack");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string what);
    wb(1'b0, a, 32'h0);
    chk(q & m, e, what);
  endtask
  task automatic wait_stat(input logic [31:0] m, e);
    int i = 0;
    do begin
      wb(1'b0, OFS_STAT, 32'h0);
      i++;
    end while ((q & m) !== e && i < 40);
  endtask
  // Edge counts over a window; phase makes each count good to one edge only
  task automatic rates(input int e [4]);
    logic [3:0] p;
    rises = '{0, 0, 0, 0};
    p = clks;
    repeat (256) begin
      @(posedge clk_i);
      for (int k = 0; k < 4; k++) rises[k] += int'(clks[k] && !p[k]);
      p = clks;
    end
    for (int k = 0; k < 4; k++) chk(32'(rises[k] >= e[k] - 1 && rises[k] <= e[k] + 1), 32'h1, "rate");
  endtask
  task automatic t_reset;
    rd(OFS_CTRL, 32'h1f, 32'h0, "ctrl");
    rd(OFS_STAT, 32'h1f, 32'h0, "stat");
    rd(OFS_DIV, 32'h777, 32'h0, "div");
    rd(OFS_IRQ_MASK, 32'h7, 32'h0, "mask");
    rd(8'h14, 32'hffffffff, 32'h0, "unmapped");
    rates('{32, 32, 32, 32});
  endtask
  task automatic t_ext;
    wb(1'b1, OFS_IRQ_MASK, 32'h7);
    wb(1'b1, OFS_CTRL, 32'h5);
    wait_stat(32'h3, 32'h1);
    rd(OFS_STAT, 32'h1f, 32'h1, "active ext");
    chk(ext_en, 32'h1, "ext enable");
    rd(OFS_IRQ_STAT, 32'h7, 32'h4, "switch flag");
    chk(irq, 32'h1, "switch irq");
    wb(1'b1, OFS_IRQ_STAT, 32'h4);
    rd(OFS_IRQ_STAT, 32'h7, 32'h0, "w1c");
    chk(irq, 32'h0, "irq cleared");
    rates('{64, 64, 64, 64});
  endtask
  task automatic t_div;
    wb(1'b1, OFS_DIV, 32'h321);
    rd(OFS_DIV, 32'h777, 32'h321, "div");
    rates('{64, 32, 8, 4});
    wb(1'b1, OFS_DIV, 32'h0);
  endtask
  task automatic t_fail;
    run_ext <= 1'b0;
    wait_stat(32'h3, 32'h0);
    rd(OFS_STAT, 32'h7, 32'h4, "fallback");
    rd(OFS_CTRL, 32'hc, 32'h0, "select forced");
    rd(OFS_IRQ_STAT, 32'h1, 32'h1, "fail flag");
    chk(irq, 32'h1, "fail irq");
    wb(1'b1, OFS_CTRL, 32'h0);
    run_ext <= 1'b1;
    wb(1'b1, OFS_IRQ_STAT, 32'h7);
  endtask
  task automatic t_masked;
    wb(1'b1, OFS_IRQ_MASK, 32'h6);
    wb(1'b1, OFS_CTRL, 32'h1);
    run_ext <= 1'b0;
    wait_stat(32'h4, 32'h4);
    rd(OFS_IRQ_STAT, 32'h1, 32'h1, "masked flag");
    chk(irq, 32'h0, "masked irq");
    wb(1'b1, OFS_CTRL, 32'h0);
    run_ext <= 1'b1;
    wb(1'b1, OFS_IRQ_STAT, 32'h7);
  endtask
  task automatic t_pll;
    wb(1'b1, OFS_CTRL, 32'ha);
    wait_stat(32'h3, 32'h2);
    rd(OFS_STAT, 32'h3, 32'h2, "active pll");
    wb(1'b1, OFS_CTRL, 32'h1b);
    run_ext <= 1'b0;
    wait_stat(32'hb, 32'h8);
    rd(OFS_STAT, 32'hb, 32'h8, "pll fail");
    rd(OFS_IRQ_STAT, 32'h2, 32'h2, "pll flag");
    chk(irq, 32'h1, "pll irq");
  endtask
  initial begin
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    run_ext = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_ext;
    t_div;
    t_fail;
    t_masked;
    t_pll;
    report_and_stop;
  end
endmodule // clk_ctrl_test
`default_nettype wire
